// ===== design/boot_mode_params.svh
`ifndef BOOT_MODE_PARAMS_SVH
`define BOOT_MODE_PARAMS_SVH

// ----------
// clock
// ----------
`define MCLK_PERIOD_NS   10
`define CYC_PER_MS       (1000000 / `MCLK_PERIOD_NS)

// ----------
// timing
// ----------
`define RESET_MIN_CYCLES 12
`define PROG_TIME_NS     20000
`define PROG_CYCLES      (`PROG_TIME_NS / `MCLK_PERIOD_NS)
`define ERASE_TIME_MS    30000
`define VERIFY_CYCLES    2

// ----------
// register offsets
// ----------
`define MODE_STATUS_OFS  8'h00
`define FLASH_CMD_OFS    8'h04
`define FLASH_STATUS_OFS 8'h08
`define FLASH_CTRL_OFS   8'h0c

// ----------
// field positions
// ----------
`define CMD_BLOCK_LSB    4
`define CMD_MASK_LSB     16
`define ST_DONE_BIT      1
`define ST_REFUSED_BIT   2

// ----------
// reset values
// ----------
`define CTRL_RESET       1'b0
`define PROTECT_RESET    16'h0000

`endif

// ===== design/boot_mode_pkg.sv
package boot_mode_pkg;

  // flash operating mode, one-hot
  typedef enum logic [3:0] {
    MODE_ICHIP  = 4'h1,  // single chip, interleaved fetch
    MODE_SCHIP  = 4'h2,  // single chip, one-clock fetch
    MODE_SBOOT  = 4'h4,  // serial boot from mask rom
    MODE_WRITER = 4'h8   // external programmer, core halted
  } mode_e;

  // flash command codes
  typedef enum logic [2:0] {
    CMD_NONE     = 3'h0,
    CMD_PROG     = 3'h1,
    CMD_SEC_PROG = 3'h2,
    CMD_CHIP_ERS = 3'h3,
    CMD_BLK_ERS  = 3'h4,
    CMD_MULT_ERS = 3'h5,
    CMD_PROTECT  = 3'h6
  } cmd_e;

  // command engine states, one-hot
  typedef enum logic [2:0] {
    ENG_IDLE   = 3'h1,
    ENG_WORK   = 3'h2,
    ENG_VERIFY = 3'h4
  } eng_e;

endpackage

// ===== design/flash_cmd_if.sv
`timescale 1ns/1ps

// command path between the register side and the flash engine
interface flash_cmd_if;
  logic                start;    // one-cycle command pulse
  boot_mode_pkg::cmd_e cmd;      // command code
  logic [3:0]          block;    // target block
  logic [15:0]         mask;     // multi-block erase selection
  logic                sec_en;   // security arm from software
  logic                busy;     // algorithm running
  logic                done;     // one-cycle completion pulse
  logic                refused;  // one-cycle refusal pulse
  logic                secure;   // stored data hidden from programmer
  logic [15:0]         protect;  // per-block protection

  modport ctrl (output start, cmd, block, mask, sec_en,
                input  busy, done, refused, secure, protect);
  modport eng  (input  start, cmd, block, mask, sec_en,
                output busy, done, refused, secure, protect);
endinterface

// ===== design/flash_cmd_engine.sv
`timescale 1ns/1ps
`include "boot_mode_params.svh"

module flash_cmd_engine #(
  parameter logic [31:0] ERASE_CYCLES = 32'd1000
) (
  input  wire logic   clk,
  input  wire logic   rst,
  flash_cmd_if.eng    cif
);

  // ----------
  // state
  // ----------
  typedef struct packed {
    boot_mode_pkg::eng_e state;    // engine phase
    boot_mode_pkg::cmd_e op;       // operation in flight
    logic [31:0]         cnt;      // cycles left in phase
    logic                done;     // completion pulse
    logic                refused;  // refusal pulse
    logic                secure;   // security latched
    logic [15:0]         protect;  // protection bits
  } eng_s;

  eng_s st;       // registered state
  eng_s next_st;  // next state

  // ----------
  // sequencing
  // ----------
  // whole algorithm runs in hardware after one command pulse
  always_comb begin
    next_st         = st;
    next_st.done    = 1'b0;
    next_st.refused = 1'b0;
    case (st.state)
      boot_mode_pkg::ENG_IDLE: begin
        if (cif.start) begin
          case (cif.cmd)
            // protection set only by command R11
            boot_mode_pkg::CMD_PROTECT: begin
              next_st.protect[cif.block] = 1'b1;
              next_st.done               = 1'b1;
            end
            boot_mode_pkg::CMD_PROG,
            boot_mode_pkg::CMD_SEC_PROG,
            boot_mode_pkg::CMD_BLK_ERS: begin
              if (st.protect[cif.block]) begin
                next_st.refused = 1'b1;
              end else begin
                next_st.op    = cif.cmd;
                next_st.state = boot_mode_pkg::ENG_WORK;  // R15
                next_st.cnt   = (cif.cmd == boot_mode_pkg::CMD_BLK_ERS)
                              ? ERASE_CYCLES : 32'(`PROG_CYCLES);
              end
            end
            // chip and multi erase start with no protection check
            boot_mode_pkg::CMD_CHIP_ERS,
            boot_mode_pkg::CMD_MULT_ERS: begin
              next_st.op    = cif.cmd;
              next_st.state = boot_mode_pkg::ENG_WORK;  // R15
              next_st.cnt   = ERASE_CYCLES;
            end
            default: begin
              next_st.refused = 1'b1;
            end
          endcase
        end
      end
      boot_mode_pkg::ENG_WORK: begin
        // no suspend or resume: new commands bounce R12
        next_st.refused = cif.start;
        if (st.cnt <= 32'd1) begin
          next_st.state = boot_mode_pkg::ENG_VERIFY;
          next_st.cnt   = 32'(`VERIFY_CYCLES);
        end else begin
          next_st.cnt = st.cnt - 32'd1;
        end
      end
      boot_mode_pkg::ENG_VERIFY: begin
        next_st.refused = cif.start;  // R12
        if (st.cnt <= 32'd1) begin
          // security program arms read blocking R13
          if (st.op == boot_mode_pkg::CMD_SEC_PROG && cif.sec_en) begin
            next_st.secure = 1'b1;  // R14
          end
          next_st.done  = 1'b1;
          next_st.state = boot_mode_pkg::ENG_IDLE;
        end else begin
          next_st.cnt = st.cnt - 32'd1;
        end
      end
      default: begin
        next_st.state = boot_mode_pkg::ENG_IDLE;
      end
    endcase
    if (rst) begin
      next_st = '{state: boot_mode_pkg::ENG_IDLE,
                  op: boot_mode_pkg::CMD_NONE, cnt: 32'h0,
                  done: 1'b0, refused: 1'b0, secure: 1'b0,
                  protect: `PROTECT_RESET};
    end
  end

  // state register
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // outputs
  assign cif.busy    = (st.state != boot_mode_pkg::ENG_IDLE);
  assign cif.done    = st.done;
  assign cif.refused = st.refused;
  assign cif.secure  = st.secure;
  assign cif.protect = st.protect;

endmodule

// ===== design/flash_boot_mode_select.sv
`timescale 1ns/1ps
`include "boot_mode_params.svh"

// Functional notes
// R1: straps pick flash mode during reset
// R2: boot and interleave pins freed after reset
// R3: core runs after reset except writer mode
// R4: programmer holds reset low in writer mode
// R5: mode straps stay stable while mode used
// R6: writer mode pin0 high, pins1-2 low
// R7: don't-care straps driven, never floating
// R8: reset held at least twelve clocks
// R9: single chip fetches flash, fetch per strap
// R10: single boot runs from mask boot rom
// R11: block protection only by software command
// R12: no erase suspend or resume
// R13: extra security auto-program command
// R14: security blocks programmer data reads
// R15: program and erase sequenced in hardware
// R16: no hardware normal/user-boot selection
// R17: board straps interleave at high clock
// R18: straps captured at reset release, held
module flash_boot_mode_select #(
  parameter logic [31:0] ERASE_CYCLES =
    32'(64'(`ERASE_TIME_MS) * 64'(`CYC_PER_MS))
) (
  input  wire logic        MCLK,
  input  wire logic        RESET,
  input  wire logic        WIDTH_STRAP_A,
  input  wire logic        WIDTH_STRAP_B,
  input  wire logic        BOOT_SELECT_STRAP,
  input  wire logic        INTERLEAVE_SELECT_STRAP,
  input  wire logic        PORT4_PIN0,
  input  wire logic        PORT4_PIN1,
  input  wire logic        PORT4_PIN2,
  input  wire logic        EXT_READ_REQ,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             CPU_RUN,
  output logic             FETCH_FLASH,
  output logic             FETCH_INTERLEAVE,
  output logic             FETCH_BOOT_ROM,
  output logic             STRAP_PINS_FREE,
  output logic             WRITER_PIN_FAULT,
  output logic             RESET_TOO_SHORT,
  output logic             EXT_READ_GRANT
);

  // ----------------------------------------------------------------------
  // pin vector positions
  // ----------------------------------------------------------------------
  localparam int PIN_BWA  = 0;  // width strap a
  localparam int PIN_BWB  = 1;  // width strap b
  localparam int PIN_BOOT = 2;  // boot select, low selects serial boot
  localparam int PIN_ILV  = 3;  // interleave select
  localparam int PIN_P40  = 4;  // port 4 pin 0
  localparam int PIN_P41  = 5;  // port 4 pin 1
  localparam int PIN_P42  = 6;  // port 4 pin 2
  localparam int PIN_XRD  = 7;  // programmer read request

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]           s1;         // first sync stage
    logic [7:0]           s2;         // second sync stage
    logic [7:0]           s3;         // third sync stage
    logic [7:0]           pins;       // filtered pin levels
    logic                 was_rst;    // reset seen last cycle
    logic [3:0]           rst_cnt;    // reset length, saturating
    logic                 short_rst;  // last reset too short
    boot_mode_pkg::mode_e mode;       // captured flash mode
    logic                 captured;   // mode valid
    logic                 wr_fault;   // writer port pins wrong
    logic                 rd_grant;   // programmer read allowed
    logic                 done_st;    // sticky command done
    logic                 ref_st;     // sticky command refused
    logic                 sec_en;     // security arm bit
    logic                 start;      // command pulse
    boot_mode_pkg::cmd_e  cmd;        // command code
    logic [3:0]           block;      // command block
    logic [15:0]          mask;       // command block mask
    logic [31:0]          rdata;      // read data
  } top_s;

  top_s st;       // registered state
  top_s next_st;  // next state

  flash_cmd_if cif ();  // command path to the engine

  logic [7:0] pin_raw;  // raw asynchronous pins

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // strap decode: both width straps high give the running modes
  // no strap for user boot: software picks normal or user boot
  function automatic boot_mode_pkg::mode_e decode_mode(  // R16
    input logic [7:0] p
  );
    if (!(p[PIN_BWA] && p[PIN_BWB])) begin
      decode_mode = boot_mode_pkg::MODE_WRITER;
    end else if (!p[PIN_BOOT]) begin
      decode_mode = boot_mode_pkg::MODE_SBOOT;
    end else if (p[PIN_ILV]) begin
      decode_mode = boot_mode_pkg::MODE_ICHIP;
    end else begin
      decode_mode = boot_mode_pkg::MODE_SCHIP;
    end
  endfunction

  // address decode, used only by the error answer
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == `MODE_STATUS_OFS) || (a == `FLASH_CMD_OFS) ||
               (a == `FLASH_STATUS_OFS) || (a == `FLASH_CTRL_OFS);
  endfunction

  assign pin_raw = {EXT_READ_REQ, PORT4_PIN2, PORT4_PIN1, PORT4_PIN0,
                    INTERLEAVE_SELECT_STRAP, BOOT_SELECT_STRAP,
                    WIDTH_STRAP_B, WIDTH_STRAP_A};

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.start = 1'b0;

    // three-stage synchroniser, accept once stages two and three agree
    next_st.s1 = pin_raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < 8; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.pins[i] = st.s3[i];
      end
    end

    next_st.was_rst = RESET;

    // mode capture on the first cycle after reset release
    if (st.was_rst && !RESET) begin
      next_st.mode     = decode_mode(st.pins);  // R1 R18
      next_st.captured = 1'b1;  // R18
      next_st.short_rst =
        (st.rst_cnt < 4'(`RESET_MIN_CYCLES));  // R8
    end

    // writer port pins watched for the whole of writer mode
    next_st.wr_fault = st.captured &&
      (st.mode == boot_mode_pkg::MODE_WRITER) &&
      !(st.pins[PIN_P40] && !st.pins[PIN_P41] &&
        !st.pins[PIN_P42]);  // R6

    // programmer reads only in writer mode, never when secure
    next_st.rd_grant = st.captured &&
      (st.mode == boot_mode_pkg::MODE_WRITER) &&
      st.pins[PIN_XRD] && !cif.secure;  // R14

    // sticky flags: engine pulse wins over a software clear
    if (PSEL && PENABLE && PWRITE && PADDR == `FLASH_STATUS_OFS) begin
      if (PWDATA[`ST_DONE_BIT]) begin
        next_st.done_st = 1'b0;
      end
      if (PWDATA[`ST_REFUSED_BIT]) begin
        next_st.ref_st = 1'b0;
      end
    end
    if (cif.done) begin
      next_st.done_st = 1'b1;
    end
    if (cif.refused) begin
      next_st.ref_st = 1'b1;
    end

    // register writes, taken in the access phase
    if (PSEL && PENABLE && PWRITE) begin
      case (PADDR)
        `FLASH_CMD_OFS: begin
          // one write hands the whole algorithm to hardware R15
          next_st.start = 1'b1;
          next_st.cmd   = boot_mode_pkg::cmd_e'(PWDATA[2:0]);  // R13
          next_st.block = PWDATA[`CMD_BLOCK_LSB +: 4];
          next_st.mask  = PWDATA[`CMD_MASK_LSB +: 16];
        end
        `FLASH_CTRL_OFS: begin
          next_st.sec_en = PWDATA[0];
        end
        default: begin
          next_st.sec_en = st.sec_en;
        end
      endcase
    end

    // read data loaded in the setup phase
    if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        `MODE_STATUS_OFS: begin
          next_st.rdata = {24'h0, st.short_rst, st.wr_fault,
                           st.captured, 1'b0, st.mode};
        end
        `FLASH_CMD_OFS: begin
          next_st.rdata = {st.mask, 8'h0, st.block, 1'b0, st.cmd};
        end
        `FLASH_STATUS_OFS: begin
          next_st.rdata = {cif.protect, 12'h0, cif.secure, st.ref_st,
                           st.done_st, cif.busy};
        end
        `FLASH_CTRL_OFS: begin
          next_st.rdata = {31'h0, st.sec_en};
        end
        default: begin
          next_st.rdata = 32'h0;
        end
      endcase
    end

    // synchronous reset: pins keep sampling, reset length counted
    if (RESET) begin
      // first reset cycle restarts the count, even from power-up
      if (st.was_rst) begin
        if (st.rst_cnt != 4'hf) begin
          next_st.rst_cnt = st.rst_cnt + 4'h1;
        end
      end else begin
        next_st.rst_cnt = 4'h1;
      end
      next_st.short_rst = 1'b0;
      next_st.mode      = boot_mode_pkg::MODE_SCHIP;
      next_st.captured  = 1'b0;
      next_st.wr_fault  = 1'b0;
      next_st.rd_grant  = 1'b0;
      next_st.done_st   = 1'b0;
      next_st.ref_st    = 1'b0;
      next_st.sec_en    = `CTRL_RESET;
      next_st.start     = 1'b0;
      next_st.cmd       = boot_mode_pkg::CMD_NONE;
      next_st.block     = 4'h0;
      next_st.mask      = 16'h0000;
      next_st.rdata     = 32'h0;
    end
  end

  // state register
  always_ff @(posedge MCLK) begin
    st <= next_st;
  end

  // ----------------------------------------------------------------------
  // flash command engine
  // ----------------------------------------------------------------------
  assign cif.start  = st.start;
  assign cif.cmd    = st.cmd;
  assign cif.block  = st.block;
  assign cif.mask   = st.mask;
  assign cif.sec_en = st.sec_en;

  // program and erase algorithms, verify included
  flash_cmd_engine #(
    .ERASE_CYCLES (ERASE_CYCLES)
  ) engine (
    .clk (MCLK),
    .rst (RESET),
    .cif (cif)
  );

  // ----------------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------------
  // zero wait states, error on unmapped offsets
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_hit(PADDR);
  assign PRDATA  = st.rdata;

  // ----------------------------------------------------------------------
  // mode outputs
  // ----------------------------------------------------------------------
  // core held in writer mode, which the programmer keeps in reset R3 R4
  assign CPU_RUN = st.captured &&
                   (st.mode != boot_mode_pkg::MODE_WRITER);  // R3

  // single chip runs from flash, fetch style from the captured strap R9
  assign FETCH_FLASH = st.captured &&
    (st.mode == boot_mode_pkg::MODE_ICHIP ||
     st.mode == boot_mode_pkg::MODE_SCHIP);  // R9
  assign FETCH_INTERLEAVE = st.captured &&
    (st.mode == boot_mode_pkg::MODE_ICHIP);  // R9

  // serial boot runs the mask rom loader
  assign FETCH_BOOT_ROM = st.captured &&
    (st.mode == boot_mode_pkg::MODE_SBOOT);  // R10

  // once captured, the straps no longer matter to the mode
  assign STRAP_PINS_FREE  = st.captured;  // R2
  assign WRITER_PIN_FAULT = st.wr_fault;  // R6
  assign RESET_TOO_SHORT  = st.short_rst;  // R8
  assign EXT_READ_GRANT   = st.rd_grant;  // R14

endmodule

// ===== tb/board_strap_model.sv
`timescale 1ns/1ps

// ----------
// board strap logic or programmer, mode picked by the bench
// ----------
module board_strap_model (
  input  wire logic [1:0] mode,
  input  wire logic       pins_ok,
  output logic            width_a,
  output logic            width_b,
  output logic            boot_sel,
  output logic            interleave_select_strap_sel,
  output logic            port4_pin0,
  output logic            port4_pin1,
  output logic            port4_pin2
);
  // 0 interleave, 1 one-clock, 2 serial boot, 3 writer
  assign width_a   = (mode != 2'd3);
  assign width_b   = 1'b1;
  assign boot_sel  = (mode != 2'd2);
  // the bench clock is 100 MHz; interleave strapped high only in mode 0
  assign interleave_select_strap_sel = (mode == 2'd0);
  // writer pins 1,0,0 unless a scenario asks for a bad pattern
  assign port4_pin0 = (mode == 2'd3) && pins_ok;
  assign port4_pin1 = (mode == 2'd3) && !pins_ok;
  assign port4_pin2 = 1'b0;
  // mode changes while the bench holds reset, and once after release in t_reuse
endmodule

// ===== tb/boot_mode_checker_props.sv
`timescale 1ns/1ps

module boot_mode_checker (
  input wire logic       MCLK,
  input wire logic       RESET,
  input wire logic       WIDTH_STRAP_A,
  input wire logic       WIDTH_STRAP_B,
  input wire logic       BOOT_SELECT_STRAP,
  input wire logic       INTERLEAVE_SELECT_STRAP,
  input wire logic       PORT4_PIN0,
  input wire logic       PORT4_PIN1,
  input wire logic       PORT4_PIN2,
  input wire logic       PSEL,
  input wire logic       PENABLE,
  input wire logic [7:0] PADDR,
  input wire logic       PREADY,
  input wire logic       PSLVERR,
  input wire logic       CPU_RUN,
  input wire logic       FETCH_FLASH,
  input wire logic       FETCH_INTERLEAVE,
  input wire logic       FETCH_BOOT_ROM,
  input wire logic       STRAP_PINS_FREE,
  input wire logic       WRITER_PIN_FAULT,
  input wire logic       RESET_TOO_SHORT,
  input wire logic       EXT_READ_GRANT
);
  // ----------
  // helper state
  // ----------
  logic       live = 1'b0;  // outputs valid, one edge after release
  logic [3:0] cap  = 4'h0;  // straps seen at the last reset edge
  logic [3:0] run  = 4'h0;  // reset edges in the current reset
  logic [3:0] rlen = 4'h0;  // length of the last reset
  logic       wr;           // writer mode captured

  assign wr = !(cap[3] && cap[2]);

  // track reset length and captured straps
  always @(posedge MCLK) begin
    // valid only once a reset was long enough to fill the synchroniser
    live <= !RESET && rlen > 4'd3;
    if (RESET) begin
      cap  <= {WIDTH_STRAP_A, WIDTH_STRAP_B,
               BOOT_SELECT_STRAP, INTERLEAVE_SELECT_STRAP};
      run  <= (run == 4'hf) ? run : run + 4'h1;
      rlen <= (run == 4'hf) ? run : run + 4'h1;
    end else begin
      run <= 4'h0;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  sequence s_bad_pins;
    live && wr && {PORT4_PIN0, PORT4_PIN1, PORT4_PIN2} != 3'b100;
  endsequence
  sequence s_access;
    PSEL && PENABLE;
  endsequence

  // ----------
  // assertions
  // ----------
  a_run_mode: assert property (live |-> CPU_RUN == !wr)
    else $error("cpu run does not match mode");
  a_fetch_flash: assert property (live |-> FETCH_FLASH == (!wr && cap[1]))
    else $error("flash fetch does not match mode");
  a_fetch_interleave_select_strap: assert property (
    live |-> FETCH_INTERLEAVE == (!wr && cap[1] && cap[0]))
    else $error("interleave does not match strap");
  a_boot_rom: assert property (live |-> FETCH_BOOT_ROM == (!wr && !cap[1]))
    else $error("boot rom fetch does not match mode");
  a_pins_free: assert property (live |-> STRAP_PINS_FREE)
    else $error("strap pins not freed");
  a_mode_held: assert property (live && $past(live) |->
    $stable({CPU_RUN, FETCH_FLASH, FETCH_INTERLEAVE, FETCH_BOOT_ROM}))
    else $error("mode outputs changed after reset");
  a_short_reset: assert property (
    live |-> RESET_TOO_SHORT == (rlen < 4'd12))
    else $error("short reset flag wrong");
  a_pin_fault: assert property (s_bad_pins [*6] |-> WRITER_PIN_FAULT)
    else $error("writer pin fault missed");
  a_grant_writer: assert property (EXT_READ_GRANT |-> live && wr)
    else $error("read grant outside writer mode");
  a_apb_answer: assert property (s_access |-> PREADY &&
    PSLVERR == (PADDR[1:0] != 2'b00 || PADDR > 8'h0c))
    else $error("apb answer wrong");
endmodule

bind flash_boot_mode_select boot_mode_checker u_chk (.*);

// ===== tb/flash_boot_mode_select_test.sv
`timescale 1ns/1ps

module flash_boot_mode_select_test;
  logic        mclk, reset, psel, penable, pwrite, ext_req, pins_ok;
  logic        pready, pslverr, cpu_run, f_flash, f_interleave_select_strap, f_rom;
  logic        pins_free, pin_fault, too_short, grant, err;
  logic        wa, wb, bsel, isel, p0, p1, p2;
  logic [1:0]  mode;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_fail, n_compared;
  int          cyc = 0;

  // ----------
  // clock, far side and design
  // ----------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  board_strap_model u_board (.mode(mode), .pins_ok(pins_ok),
    .width_a(wa), .width_b(wb), .boot_sel(bsel), .interleave_select_strap_sel(isel),
    .port4_pin0(p0), .port4_pin1(p1), .port4_pin2(p2));

  flash_boot_mode_select #(.ERASE_CYCLES(32'd20)) u_dut (
    .MCLK(mclk), .RESET(reset), .WIDTH_STRAP_A(wa), .WIDTH_STRAP_B(wb),
    .BOOT_SELECT_STRAP(bsel), .INTERLEAVE_SELECT_STRAP(isel),
    .PORT4_PIN0(p0), .PORT4_PIN1(p1), .PORT4_PIN2(p2),
    .EXT_READ_REQ(ext_req), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CPU_RUN(cpu_run),
    .FETCH_FLASH(f_flash), .FETCH_INTERLEAVE(f_interleave_select_strap),
    .FETCH_BOOT_ROM(f_rom), .STRAP_PINS_FREE(pins_free),
    .WRITER_PIN_FAULT(pin_fault), .RESET_TOO_SHORT(too_short),
    .EXT_READ_GRANT(grant));

  // ----------
  // shared tasks
  // ----------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer; read data and error land in rd and err
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // read status until the given bit is up, bounded
  task automatic poll(input int b);
    int k;
    k = 0;
    do begin
      apb(1'b0, 8'h08, 32'h0);
      k++;
    end while (rd[b] !== 1'b1 && k < 1500);
  endtask

  task automatic do_reset(input logic [1:0] m, input int n);
    @(posedge mclk);
    reset <= 1'b1;
    mode <= m;
    repeat (n) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  // run, flash, interleave, rom, pins free
  function automatic logic [31:0] exp_out(input logic [1:0] m);
    return 32'({m != 2'd3, m < 2'd2, m == 2'd0, m == 2'd2, 1'b1});
  endfunction

  function automatic logic [31:0] cmdw(input logic [2:0] c,
                                       input logic [3:0] b);
    return {16'h0080, 8'h00, b, 1'b0, c};
  endfunction

  // ----------
  // scenarios
  // ----------
  task automatic t_short();
    chk(32'(too_short), 32'h1);
    do_reset(2'd0, 11);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'ha1);
    do_reset(2'd0, 12);
    chk(32'(too_short), 32'h0);
    $display("done t_short");
  endtask

  task automatic t_modes();
    for (int i = 0; i < 4; i++) begin
      do_reset(2'(i), 12);
      chk(32'({cpu_run, f_flash, f_interleave_select_strap, f_rom, pins_free}),
          exp_out(2'(i)));
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h20 | (32'h1 << i));
    end
    $display("done t_modes");
  endtask

  // boot and interleave pins reused after release
  task automatic t_reuse();
    do_reset(2'd0, 12);
    mode <= 2'd2;
    repeat (8) @(posedge mclk);
    chk(32'({cpu_run, f_flash, f_interleave_select_strap, f_rom, pins_free}),
        exp_out(2'd0));
    $display("done t_reuse");
  endtask

  task automatic t_flash();
    logic [2:0] tbl [6] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h0, 3'h7};
    int b;
    apb(1'b1, 8'h04, cmdw(3'h1, 4'h3));
    poll(1);
    chk(rd & 32'h7, 32'h2);
    apb(1'b1, 8'h08, 32'h6);
    apb(1'b1, 8'h04, cmdw(3'h6, 4'h3));
    repeat (3) @(posedge mclk);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd >> 16, 32'h8);
    apb(1'b1, 8'h08, 32'h6);
    apb(1'b1, 8'h04, cmdw(3'h1, 4'h3));
    poll(2);
    chk(rd & 32'h6, 32'h4);
    apb(1'b1, 8'h08, 32'h6);
    // a second command during an erase is refused, erase completes
    apb(1'b1, 8'h04, cmdw(3'h4, 4'h5));
    apb(1'b1, 8'h04, cmdw(3'h3, 4'h0));
    poll(1);
    chk(rd & 32'h6, 32'h6);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'h08, 32'h6);
      b = (tbl[i] == 3'h0 || tbl[i] == 3'h7) ? 2 : 1;
      apb(1'b1, 8'h04, cmdw(tbl[i], 4'h7));
      poll(b);
      chk(rd & 32'h6, 32'h1 << b);
    end
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h00, 32'hff);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h21);
    $display("done t_flash");
  endtask

  task automatic t_writer();
    int k;
    do_reset(2'd3, 12);
    ext_req <= 1'b1;
    k = 0;
    while (grant !== 1'b1 && k < 10) begin
      @(posedge mclk);
      k++;
    end
    chk(32'(grant), 32'h1);
    apb(1'b1, 8'h0c, 32'h1);
    apb(1'b1, 8'h04, cmdw(3'h2, 4'h1));
    poll(1);
    chk(rd & 32'h8, 32'h8);
    repeat (6) @(posedge mclk);
    chk(32'(grant), 32'h0);
    pins_ok <= 1'b0;
    k = 0;
    while (pin_fault !== 1'b1 && k < 10) begin
      @(posedge mclk);
      k++;
    end
    chk(32'(pin_fault), 32'h1);
    ext_req <= 1'b0;
    $display("done t_writer");
  endtask

  // ----------
  // run control
  // ----------
  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // cut a hang short
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 40000) begin
      n_fail++;
      $display("BAD %0t timeout", $time);
      end_of_test();
    end
  end

  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, ext_req} = 4'h0;
    {paddr, pwdata, mode, pins_ok} = 43'h1;
    n_fail = 0;
    n_compared = 0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    t_short();
    t_modes();
    t_reuse();
    t_flash();
    t_writer();
    end_of_test();
  end
endmodule
